/* src/pfm_pkg.sv */
// Operation
// - Pad A modes: 0 gpio,6 irq,7 fsync,12 capture
// - Pad B modes: 0 gpio,3 pwm,6,7,12
// - Deep sleep: unused pads input with pulldown
// - Hibernate: pads A and B Hi-Z, no pulls
// - Strap pad drives high; hibernate floats pulled down
// - Software-set boot bit in control register enables digital path
// - ADC switch resets off; pad Hi-Z first
package pfm_pkg;
  localparam logic [31:0] PFM_ADDR_PAD_A = 32'h4402e0c0;
  localparam logic [31:0] PFM_ADDR_PAD_B = 32'h4402e0c4;
  localparam logic [31:0] PFM_ADDR_CTRL = 32'h4402e0c8;
  localparam logic [31:0] PFM_ADDR_STAT = 32'h4402e0cc;
  localparam logic [3:0] PFM_MODE_GPIO = 4'h0;
  localparam logic [3:0] PFM_MODE_PWM = 4'h3;
  localparam logic [3:0] PFM_MODE_CARD = 4'h6;
  localparam logic [3:0] PFM_MODE_AUDIO = 4'h7;
  localparam logic [3:0] PFM_MODE_CAPT = 4'hc;
  // Pad config fields
  localparam int PFM_MODE_LSB = 0;
  localparam int PFM_PU_BIT = 8;
  localparam int PFM_PD_BIT = 9;
  localparam int PFM_USED_BIT = 10;
  localparam int PFM_GOUT_BIT = 11;
  localparam int PFM_GOE_BIT = 12;
  localparam int PFM_ADC_BIT = 13;
  // Control register fields
  localparam int PFM_SLEEP_BIT = 0;
  localparam int PFM_HIB_BIT = 1;
  localparam int PFM_BOOT_BIT = 2;
  localparam logic [31:0] PFM_PAD_RESET = 32'h00000000;
  localparam logic [1:0] PFM_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] PFM_HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {PFM_PWR_RUN, PFM_PWR_SLEEP, PFM_PWR_HIB} pfm_pwr_e;

  typedef struct packed {
    logic out;
    logic oe;
    logic pu;
    logic pd;
    logic ie;
  } pfm_pad_s;

  typedef struct packed {
    logic [3:0] mode;
    logic pu;
    logic pd;
    logic used;
    logic gout;
    logic goe;
    logic adc;
  } pfm_cfg_s;

  function automatic pfm_cfg_s pfm_decode(input logic [31:0] r);
    pfm_cfg_s c;
    c.mode = r[PFM_MODE_LSB +: 4];
    c.pu = r[PFM_PU_BIT];
    c.pd = r[PFM_PD_BIT];
    c.used = r[PFM_USED_BIT];
    c.gout = r[PFM_GOUT_BIT];
    c.goe = r[PFM_GOE_BIT];
    c.adc = r[PFM_ADC_BIT];
    return c;
  endfunction : pfm_decode
endpackage : pfm_pkg

/* src/pfm_pad_cell.sv */
`timescale 1ns/1ps
`default_nettype none
module pfm_pad_cell
  import pfm_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Configuration
  input wire pfm_cfg_s cfg,
  input wire pfm_pwr_e pwr,
  input wire logic dig_en,
  // Selected function drive
  input wire logic fn_out,
  input wire logic fn_oe,
  input wire logic fn_ok,
  // Pad side
  output pfm_pad_s pad
);
  pfm_pad_s pad_next;

  always_comb begin
    pad_next = '0;
    unique case (pwr)
      PFM_PWR_HIB: pad_next = '0;
      PFM_PWR_SLEEP: begin
        if (!cfg.used) begin
          pad_next.pd = 1'b1;
          pad_next.ie = 1'b1;
        end else begin
          pad_next.pu = cfg.pu;
          pad_next.pd = cfg.pd;
          pad_next.ie = 1'b1;
        end
      end
      default: begin
        pad_next.pu = cfg.pu;
        pad_next.pd = cfg.pd;
        pad_next.ie = dig_en;
        // Analog switch needs a released pad
        if (dig_en && fn_ok && !cfg.adc) begin
          pad_next.out = fn_out;
          pad_next.oe = fn_oe;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad <= '0;
    end else begin
      pad <= pad_next;
    end
  end
endmodule : pfm_pad_cell
`default_nettype wire

/* src/pfm_top.sv */
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module pfm_top
  import pfm_pkg::*;
(
  // AHB-Lite
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Peripheral side
  input wire logic audio_frame_sync_out,
  input wire logic pwm_out5,
  input wire logic card_data_bit0_out,
  input wire logic card_data_bit0_oe,
  input wire logic audio_serial_data0_out,
  input wire logic audio_serial_data0_oe,
  output logic card_interrupt_in,
  output logic timer_capture_in6,
  output logic timer_capture_in0,
  output logic card_data_bit0_in,
  output logic audio_serial_data0_in,
  // Pads
  output pfm_pad_s general_pad_a,
  input wire logic general_pad_a_in,
  output pfm_pad_s general_pad_b,
  input wire logic general_pad_b_in,
  output pfm_pad_s powerup_mode_strap2,
  // ADC pass switch
  output logic adc_switch_b
);
  logic [31:0] pad_a_reg;
  logic [31:0] pad_b_reg;
  logic [2:0] ctrl_reg;
  logic wr_pend_reg;
  logic [31:0] wr_addr_reg;
  pfm_cfg_s cfg_a;
  pfm_cfg_s cfg_b;
  pfm_pwr_e pwr;
  logic fa_out, fa_oe, fa_ok, fb_out, fb_oe, fb_ok;
  logic adc_next;
  logic acc;

  assign cfg_a = pfm_decode(pad_a_reg);
  assign cfg_b = pfm_decode(pad_b_reg);
  assign acc = hsel && hready && htrans == PFM_HTRANS_NONSEQ && hsize == PFM_HSIZE_WORD;

  always_comb begin
    if (ctrl_reg[PFM_HIB_BIT]) begin
      pwr = PFM_PWR_HIB;
    end else if (ctrl_reg[PFM_SLEEP_BIT]) begin
      pwr = PFM_PWR_SLEEP;
    end else begin
      pwr = PFM_PWR_RUN;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_reg <= acc && hwrite;
      if (acc) begin
        wr_addr_reg <= haddr;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (acc && !hwrite) begin
      unique case (haddr)
        PFM_ADDR_PAD_A: hrdata <= pad_a_reg;
        PFM_ADDR_PAD_B: hrdata <= pad_b_reg;
        PFM_ADDR_CTRL: hrdata <= {29'h0, ctrl_reg};
        PFM_ADDR_STAT: hrdata <= {27'h0, adc_switch_b, general_pad_b_in, general_pad_a_in,
                                  general_pad_b.oe, general_pad_a.oe};
        default: hrdata <= '0;
      endcase
    end
  end

  // Config writes; modes reset to gpio
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_a_reg <= PFM_PAD_RESET;
      pad_b_reg <= PFM_PAD_RESET;
      ctrl_reg <= '0;
    end else if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        PFM_ADDR_PAD_A: pad_a_reg <= hwdata;
        PFM_ADDR_PAD_B: pad_b_reg <= hwdata;
        PFM_ADDR_CTRL: ctrl_reg <= hwdata[2:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Function select
  always_comb begin
    fa_out = 1'b0;
    fa_oe = 1'b0;
    fa_ok = 1'b1;
    unique case (cfg_a.mode)
      PFM_MODE_GPIO: begin
        fa_out = cfg_a.gout;
        fa_oe = cfg_a.goe;
      end
      PFM_MODE_CARD, PFM_MODE_CAPT: fa_oe = 1'b0;
      PFM_MODE_AUDIO: begin
        fa_out = audio_frame_sync_out;
        fa_oe = 1'b1;
      end
      default: fa_ok = 1'b0;
    endcase
  end

  always_comb begin
    fb_out = 1'b0;
    fb_oe = 1'b0;
    fb_ok = 1'b1;
    unique case (cfg_b.mode)
      PFM_MODE_GPIO: begin
        fb_out = cfg_b.gout;
        fb_oe = cfg_b.goe;
      end
      PFM_MODE_PWM: begin
        fb_out = pwm_out5;
        fb_oe = 1'b1;
      end
      PFM_MODE_CARD: begin
        fb_out = card_data_bit0_out;
        fb_oe = card_data_bit0_oe;
      end
      PFM_MODE_AUDIO: begin
        fb_out = audio_serial_data0_out;
        fb_oe = audio_serial_data0_oe;
      end
      PFM_MODE_CAPT: fb_oe = 1'b0;
      default: fb_ok = 1'b0;
    endcase
  end

  // Inputs routed only when mode selects them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      card_interrupt_in <= 1'b0;
      timer_capture_in6 <= 1'b0;
      timer_capture_in0 <= 1'b0;
      card_data_bit0_in <= 1'b0;
      audio_serial_data0_in <= 1'b0;
    end else begin
      card_interrupt_in <= cfg_a.mode == PFM_MODE_CARD && general_pad_a_in;
      timer_capture_in6 <= cfg_a.mode == PFM_MODE_CAPT && general_pad_a_in;
      timer_capture_in0 <= cfg_b.mode == PFM_MODE_CAPT && general_pad_b_in;
      card_data_bit0_in <= cfg_b.mode == PFM_MODE_CARD && general_pad_b_in;
      audio_serial_data0_in <= cfg_b.mode == PFM_MODE_AUDIO && general_pad_b_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pads
  pfm_pad_cell u_pad_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .cfg(cfg_a),
    .pwr(pwr),
    .dig_en(ctrl_reg[PFM_BOOT_BIT]),
    .fn_out(fa_out),
    .fn_oe(fa_oe),
    .fn_ok(fa_ok),
    .pad(general_pad_a)
  );

  pfm_pad_cell u_pad_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .cfg(cfg_b),
    .pwr(pwr),
    .dig_en(ctrl_reg[PFM_BOOT_BIT]),
    .fn_out(fb_out),
    .fn_oe(fb_oe),
    .fn_ok(fb_ok),
    .pad(general_pad_b)
  );

  // Switch closes only once the pad driver is already off
  assign adc_next = cfg_b.adc && !general_pad_b.oe && pwr == PFM_PWR_RUN;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_switch_b <= 1'b0;
    end else begin
      adc_switch_b <= adc_next;
    end
  end

  // Strap pad: driven high, pulled down in hibernate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      powerup_mode_strap2 <= '{out: 1'b1, oe: 1'b1, pu: 1'b0, pd: 1'b0, ie: 1'b0};
    end else if (pwr == PFM_PWR_HIB) begin
      powerup_mode_strap2 <= '{out: 1'b0, oe: 1'b0, pu: 1'b0, pd: 1'b1, ie: 1'b0};
    end else begin
      powerup_mode_strap2 <= '{out: 1'b1, oe: 1'b1, pu: 1'b0, pd: 1'b0, ie: 1'b0};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  AST_HIB_HIZ: assert property (@(posedge hclk) disable iff (!hresetn)
    pwr == PFM_PWR_HIB |=> general_pad_a == '0 && general_pad_b == '0)
    else $error("pad not released in hibernate");
  AST_SLEEP_PD: assert property (@(posedge hclk) disable iff (!hresetn)
    pwr == PFM_PWR_SLEEP && !cfg_a.used |=> general_pad_a.pd && !general_pad_a.oe)
    else $error("unused pad lacks pulldown in sleep");
  AST_STRAP_HIB: assert property (@(posedge hclk) disable iff (!hresetn)
    pwr == PFM_PWR_HIB |=> powerup_mode_strap2.pd && !powerup_mode_strap2.oe)
    else $error("strap pad wrong in hibernate");
  AST_STRAP_RUN: assert property (@(posedge hclk) disable iff (!hresetn)
    pwr != PFM_PWR_HIB |=> powerup_mode_strap2.oe && powerup_mode_strap2.out)
    else $error("strap pad not driven high");
  AST_ADC_SAFE: assert property (@(posedge hclk) disable iff (!hresetn)
    adc_switch_b |-> !$past(general_pad_b.oe))
    else $error("switch closed with driver on");
  AST_ADC_OE: assert property (@(posedge hclk) disable iff (!hresetn)
    adc_switch_b |-> !general_pad_b.oe)
    else $error("pad driven while switch closed");
  AST_BADMODE: assert property (@(posedge hclk) disable iff (!hresetn)
    !fa_ok ##1 !fa_ok |-> !general_pad_a.oe)
    else $error("unlisted mode drives pad");
  AST_PWM: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_b.mode == PFM_MODE_PWM && pwr == PFM_PWR_RUN && ctrl_reg[PFM_BOOT_BIT] && !cfg_b.adc
    |=> general_pad_b.oe && general_pad_b.out == $past(pwm_out5))
    else $error("pwm not routed");
  AST_FSYNC: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_a.mode == PFM_MODE_AUDIO && pwr == PFM_PWR_RUN && ctrl_reg[PFM_BOOT_BIT] && !cfg_a.adc
    |=> general_pad_a.oe && general_pad_a.out == $past(audio_frame_sync_out))
    else $error("frame sync not routed");
  AST_BOOT: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_reg[PFM_BOOT_BIT] && pwr == PFM_PWR_RUN |=> !general_pad_a.oe)
    else $error("pad driven before digital path enabled");
  COV_HIB: cover property (@(posedge hclk) disable iff (!hresetn) pwr == PFM_PWR_HIB);
  COV_ADC: cover property (@(posedge hclk) disable iff (!hresetn) adc_switch_b);
  COV_PWM: cover property (@(posedge hclk) disable iff (!hresetn) general_pad_b.oe && cfg_b.mode == PFM_MODE_PWM);
endmodule : pfm_top
`default_nettype wire

/* tb/pfm_board_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pfm_board_model
  import pfm_pkg::*;
(
  // Pads from the device
  input wire pfm_pad_s pad_a,
  input wire pfm_pad_s pad_b,
  input wire pfm_pad_s strap,
  // Levels the external parts drive
  input wire logic ext_a,
  input wire logic ext_b,
  // Pad levels back to the device
  output logic a_in,
  output logic b_in,
  output logic strap_level
);
  // Device driver wins, then internal pulls, then the external part
  assign a_in = pad_a.oe ? pad_a.out : pad_a.pu ? 1'b1 : pad_a.pd ? 1'b0 : ext_a;
  assign b_in = pad_b.oe ? pad_b.out : pad_b.pu ? 1'b1 : pad_b.pd ? 1'b0 : ext_b;
  // Board resistor holds the strap; the board only ever listens to it
  assign strap_level = strap.oe ? strap.out : 1'b0;
endmodule : pfm_board_model
`default_nettype wire

/* tb/pad_function_mux_lowpower_states_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pad_function_mux_lowpower_states_tb;
  import pfm_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, f;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic fs, pwm, cd_out, cd_oe, ax_out, ax_oe, ext_a, ext_b, a_in, b_in;
  logic irq_in, cap6, cap0, cd_in, ax_in, adc_sw;
  pfm_pad_s pa, pb, strap;
  integer seed = 32'hc2a2;
  int n_errors = 0;
  int compares = 0;
  logic [3:0] ma [6] = '{PFM_MODE_GPIO, PFM_MODE_CARD, PFM_MODE_AUDIO, PFM_MODE_CAPT, 4'h5, 4'hf};
  logic [3:0] mb [6] = '{PFM_MODE_GPIO, PFM_MODE_PWM, PFM_MODE_CARD, PFM_MODE_AUDIO, PFM_MODE_CAPT, 4'h9};
  assign hready = hreadyout;

  pfm_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .audio_frame_sync_out(fs), .pwm_out5(pwm), .card_data_bit0_out(cd_out), .card_data_bit0_oe(cd_oe),
    .audio_serial_data0_out(ax_out), .audio_serial_data0_oe(ax_oe), .card_interrupt_in(irq_in),
    .timer_capture_in6(cap6), .timer_capture_in0(cap0), .card_data_bit0_in(cd_in),
    .audio_serial_data0_in(ax_in), .general_pad_a(pa), .general_pad_a_in(a_in), .general_pad_b(pb),
    .general_pad_b_in(b_in), .powerup_mode_strap2(strap), .adc_switch_b(adc_sw));

  pfm_board_model board (.pad_a(pa), .pad_b(pb), .strap(strap), .ext_a(ext_a), .ext_b(ext_b), .a_in(a_in),
    .b_in(b_in), .strap_level());

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (n_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      stop_test();
    end
  endtask : wait_rdy

  // Address phase held until hready, then data phase until hready again
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= PFM_HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= PFM_HSIZE_WORD;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task automatic settle;
    repeat (5) @(posedge hclk);
  endtask : settle

  ////////////////////////////////////////////////////////////////////////
  // Flags are {adc, goe, gout, used, pd, pu}
  function automatic logic [31:0] mk(input logic [3:0] m, input logic [5:0] fl);
    return {18'h0, fl, 4'h0, m};
  endfunction : mk

  function automatic logic [31:0] exp_a(input logic [3:0] m, input logic go, input logic ge);
    logic oe, o;
    oe = (m == PFM_MODE_GPIO) ? ge : (m == PFM_MODE_AUDIO);
    o = (m == PFM_MODE_GPIO) ? go : fs;
    return {28'h0, oe, oe & o, (m == PFM_MODE_CARD) & ext_a, (m == PFM_MODE_CAPT) & ext_a};
  endfunction : exp_a

  function automatic logic [31:0] exp_b(input logic [3:0] m, input logic go, input logic ge);
    logic oe, o, l;
    oe = m == PFM_MODE_GPIO ? ge : m == PFM_MODE_PWM ? 1'b1 : m == PFM_MODE_CARD ? cd_oe :
      m == PFM_MODE_AUDIO ? ax_oe : 1'b0;
    o = m == PFM_MODE_GPIO ? go : m == PFM_MODE_PWM ? pwm : m == PFM_MODE_CARD ? cd_out : ax_out;
    l = oe ? o : ext_b;
    return {27'h0, oe, oe & o, (m == PFM_MODE_CARD) & l, (m == PFM_MODE_AUDIO) & l, (m == PFM_MODE_CAPT) & l};
  endfunction : exp_b

  ////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  initial begin
    {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {fs, pwm, cd_out, cd_oe, ax_out, ax_oe, ext_a, ext_b} = '0;
    repeat (6) @(posedge hclk);
    chk({strap.out, strap.oe, adc_sw}, 3'b110);
    chk({pa, pb}, '0);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(PFM_ADDR_PAD_A, 1'b0, '0);
    chk(rd, PFM_PAD_RESET);
    chk({hreadyout, hresp}, 2'b10);
    bus(PFM_ADDR_CTRL, 1'b1, 32'h4);
    for (int i = 0; i < 6; i++) begin
      f = $random(seed);
      {fs, pwm, cd_out, cd_oe, ax_out, ax_oe, ext_a, ext_b} <= f[7:0];
      bus(PFM_ADDR_PAD_A, 1'b1, mk(ma[i], {1'b0, f[9:8], 3'b0}));
      bus(PFM_ADDR_PAD_B, 1'b1, mk(mb[i], {1'b0, f[11:10], 3'b0}));
      bus(PFM_ADDR_PAD_A, 1'b0, '0);
      chk(rd, mk(ma[i], {1'b0, f[9:8], 3'b0}));
      settle();
      chk({pa.oe, pa.oe & pa.out, irq_in, cap6}, exp_a(ma[i], f[8], f[9]));
      chk({pb.oe, pb.oe & pb.out, cd_in, ax_in, cap0}, exp_b(mb[i], f[10], f[11]));
    end
    bus(PFM_ADDR_PAD_A, 1'b1, mk(PFM_MODE_GPIO, 6'b000000));
    bus(PFM_ADDR_PAD_B, 1'b1, mk(PFM_MODE_GPIO, 6'b011101));
    bus(PFM_ADDR_CTRL, 1'b1, 32'h5);
    settle();
    chk({pa.oe, pa.pu, pa.pd, pa.ie}, 4'b0011);
    chk({pb.oe, pb.pu, pb.pd}, 3'b010);
    // Used pad with its weak pulldown on, as a flash pad would be kept in sleep
    bus(PFM_ADDR_PAD_A, 1'b1, mk(PFM_MODE_GPIO, 6'b000110));
    settle();
    chk({pa.oe, pa.pu, pa.pd, pa.ie}, 4'b0011);
    bus(PFM_ADDR_CTRL, 1'b1, 32'h7);
    settle();
    chk({pa, pb}, '0);
    chk({strap.oe, strap.pu, strap.pd}, 3'b001);
    bus(PFM_ADDR_CTRL, 1'b1, 32'h4);
    settle();
    chk({strap.out, strap.oe, pb.oe, adc_sw}, 4'b1110);
    bus(PFM_ADDR_PAD_B, 1'b1, mk(PFM_MODE_GPIO, 6'b000000));
    bus(PFM_ADDR_PAD_B, 1'b1, mk(PFM_MODE_GPIO, 6'b100000));
    settle();
    chk({pb.oe, adc_sw}, 2'b01);
    bus(PFM_ADDR_PAD_B, 1'b1, mk(PFM_MODE_GPIO, 6'b110000));
    settle();
    chk({pb.oe, adc_sw}, 2'b01);
    bus(PFM_ADDR_STAT, 1'b0, '0);
    chk(rd & 32'h12, 32'h10);
    bus(32'h4402e0d0, 1'b0, '0);
    chk(rd, '0);
    // Reset in mid-run with the switch closed: everything back to power-up state
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({strap.out, strap.oe, adc_sw, pa, pb}, 13'h1800);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(PFM_ADDR_PAD_B, 1'b0, '0);
    chk(rd, PFM_PAD_RESET);
    stop_test();
  end
endmodule : pad_function_mux_lowpower_states_tb
`default_nettype wire
